/* rtl/brg_divider.sv */
// Purpose: programmable divisor counter and bit-rate halving stage
// Assumes: base_tick is a one-cycle enable on hclk
// Notes: bit_tick is a one-cycle pulse from a flop
module brg_divider
	import brg_pkg::*;
#(
	parameter int DIV_W = 8
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic run,
	input wire logic base_tick,
	input wire logic [DIV_W-1:0] divisor,
	output logic bit_tick
);

	generate
		if (DIV_W < 2 || DIV_W > 16)
		begin : g_bad_width
			$error("brg_divider: DIV_W must lie in 2..16");
		end
	endgenerate

	typedef struct packed {
		logic [DIV_W-1:0] count;
		logic half;
		logic tick;
	} div_s;

	div_s state_reg;
	div_s state_next;

	always_comb
	begin
		state_next = state_reg;
		state_next.tick = 1'b0;
		if (!run)
		begin
			state_next.count = '0;
			state_next.half = 1'b0;
		end
		else if (base_tick)
		begin
			if (state_reg.count >= divisor)
			begin
				state_next.count = '0;
				// two counter periods per bit
				state_next.half = !state_reg.half;
				state_next.tick = state_reg.half;
			end
			else
			begin
				state_next.count = state_reg.count + 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign bit_tick = state_reg.tick;

endmodule

/* rtl/uart_baud_and_break_control.sv */
// Purpose: bit-rate generator and break-field send/receive control behind AHB-Lite
// Assumes: single word transfers; hclk 100 MHz; rxd already synchronous
// Notes: reads take one wait state, writes none; response always OKAY
//
// Added by the designer: the register offsets and register access over AHB-Lite.

//////////////////////////////////////////////////////////////////////////////
// Function
// - bit rate is the divisor counter output halved
// - rewriting break control with the same value while running is accepted
// - a write with break start set begins a fresh break operation only while power and that channel's enable are set
// - break transmit start clears itself with the completion interrupt
// - break receive flag stays one after a break receive error
// - break receive start bit always reads zero
module uart_baud_and_break_control
	import brg_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic rxd,
	output logic txd,
	output logic irq
);

	typedef struct packed {
		logic dp_write;
		logic dp_read;
		logic rd_wait;
		logic [7:0] dp_addr;
		logic [31:0] rdata;
		logic power;
		logic txe;
		logic rxe;
		logic [7:0] divisor;
		logic [3:0] clk_sel;
		logic [PRE_W-1:0] pre_cnt;
		rx_state_e rx_state;
		logic [3:0] rx_cnt;
		logic rx_flag;
		logic tx_active;
		logic [3:0] tx_cnt;
		logic txd;
		logic [IRQ_W-1:0] irq_status;
		logic [IRQ_W-1:0] irq_enable;
	} ctl_s;

	ctl_s state_reg;
	ctl_s state_next;
	logic bit_tick;
	logic base_tick;

	function automatic logic [PRE_W-1:0] pre_mask(input logic [3:0] sel);
		logic [PRE_W:0] one_hot;
		one_hot = '0;
		one_hot[sel] = 1'b1;
		pre_mask = PRE_W'(one_hot - 1'b1);
	endfunction

	function automatic logic [31:0] read_mux(input ctl_s s);
		logic [31:0] v;
		v = 32'h00000000;
		case (s.dp_addr)
			ADDR_MODE:
			begin
				v[POWER_BIT] = s.power;
				v[TXE_BIT] = s.txe;
				v[RXE_BIT] = s.rxe;
			end
			ADDR_BAUD: v[7:0] = s.divisor;
			ADDR_CLKSEL: v[3:0] = s.clk_sel;
			// start bit for reception stays zero on read
			ADDR_BREAK: v[BRK_TX_START_BIT] = s.tx_active;
			ADDR_STATUS:
			begin
				v[ST_RX_FLAG_BIT] = s.rx_flag;
				v[ST_RX_ACTIVE_BIT] = (s.rx_state != rx_idle);
				v[ST_TX_ACTIVE_BIT] = s.tx_active;
			end
			ADDR_IRQ_STATUS: v[IRQ_W-1:0] = s.irq_status;
			ADDR_IRQ_ENABLE: v[IRQ_W-1:0] = s.irq_enable;
			default: v = 32'h00000000;
		endcase
		read_mux = v;
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// base clock prescaler and divisor counter

	// a select above the top tap falls back to the slowest rate
	assign base_tick = state_reg.power &&
		((state_reg.pre_cnt & pre_mask(state_reg.clk_sel > CLKSEL_MAX ? CLKSEL_MAX : state_reg.clk_sel)) == '0);

	brg_divider #(
		.DIV_W(8)
	) u_div (
		.hclk(hclk),
		.hresetn(hresetn),
		.run(state_reg.power),
		.base_tick(base_tick),
		.divisor(state_reg.divisor),
		.bit_tick(bit_tick)
	);

	//////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		logic [IRQ_W-1:0] events;
		logic [IRQ_W-1:0] clears;
		logic rx_run;
		logic tx_run;
		events = '0;
		clears = '0;
		state_next = state_reg;
		rx_run = state_reg.power && state_reg.rxe;
		tx_run = state_reg.power && state_reg.txe;
		state_next.pre_cnt = state_reg.power ? PRE_W'(state_reg.pre_cnt + 1'b1) : '0;

		// break reception: line must stay low long enough, then rise
		if (!rx_run)
		begin
			state_next.rx_state = rx_idle;
		end
		else if (bit_tick)
		begin
			case (state_reg.rx_state)
				rx_idle: state_next.rx_state = rx_idle;
				rx_wait_low:
				begin
					if (!rxd)
					begin
						state_next.rx_state = rx_count;
						state_next.rx_cnt = 4'h1;
					end
				end
				rx_count:
				begin
					if (!rxd)
					begin
						if (state_reg.rx_cnt != 4'hF)
						begin
							state_next.rx_cnt = state_reg.rx_cnt + 4'h1;
						end
					end
					else if (state_reg.rx_cnt >= BREAK_RX_MIN_BITS)
					begin
						state_next.rx_state = rx_idle;
						state_next.rx_flag = 1'b0;
						events[IRQ_RX_DONE] = 1'b1;
					end
					else
					begin
						// flag held; software must re-arm reception
						state_next.rx_state = rx_idle;
						state_next.rx_flag = 1'b1;
						events[IRQ_RX_ERR] = 1'b1;
					end
				end
				default: state_next.rx_state = rx_idle;
			endcase
		end

		// break transmission: line low for a fixed count of bits
		if (!tx_run)
		begin
			state_next.tx_active = 1'b0;
			state_next.txd = 1'b1;
		end
		else if (state_reg.tx_active && bit_tick)
		begin
			if (state_reg.tx_cnt == BREAK_TX_BITS - 4'h1)
			begin
				state_next.tx_active = 1'b0;
				state_next.txd = 1'b1;
				events[IRQ_TX_DONE] = 1'b1;
			end
			else
			begin
				state_next.tx_cnt = state_reg.tx_cnt + 4'h1;
			end
		end

		// bus data phase
		if (state_reg.dp_write)
		begin
			state_next.dp_write = 1'b0;
			case (state_reg.dp_addr)
				ADDR_MODE:
				begin
					state_next.power = hwdata[POWER_BIT];
					state_next.txe = hwdata[TXE_BIT];
					state_next.rxe = hwdata[RXE_BIT];
				end
				// taken as written; software keeps the enables low meanwhile
				ADDR_BAUD: state_next.divisor = hwdata[7:0];
				ADDR_CLKSEL: state_next.clk_sel = hwdata[3:0];
				ADDR_BREAK:
				begin
					// same-value rewrite is legal and restarts an operation
					if (hwdata[BRK_RX_START_BIT] && rx_run)
					begin
						state_next.rx_state = rx_wait_low;
						state_next.rx_cnt = 4'h0;
						state_next.rx_flag = 1'b1;
					end
					if (hwdata[BRK_TX_START_BIT] && tx_run)
					begin
						state_next.tx_active = 1'b1;
						state_next.tx_cnt = 4'h0;
						state_next.txd = 1'b0;
					end
				end
				ADDR_IRQ_CLEAR: clears = hwdata[IRQ_W-1:0];
				ADDR_IRQ_ENABLE: state_next.irq_enable = hwdata[IRQ_W-1:0];
				default: state_next.dp_write = 1'b0;
			endcase
		end
		if (state_reg.dp_read)
		begin
			if (!state_reg.rd_wait)
			begin
				state_next.rdata = read_mux(state_reg);
				state_next.rd_wait = 1'b1;
			end
			else
			begin
				state_next.dp_read = 1'b0;
				state_next.rd_wait = 1'b0;
			end
		end

		// a new event wins over a clear in the same cycle
		state_next.irq_status = (state_reg.irq_status & ~clears) | events;

		// bus address phase
		if (hsel && htrans[1] && hready)
		begin
			state_next.dp_addr = haddr[7:0];
			state_next.dp_write = hwrite;
			state_next.dp_read = !hwrite;
			state_next.rd_wait = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg <= '{dp_write: 1'b0, dp_read: 1'b0, rd_wait: 1'b0, dp_addr: 8'h00, rdata: 32'h00000000,
				power: 1'b0, txe: 1'b0, rxe: 1'b0, divisor: DIVISOR_RESET, clk_sel: CLKSEL_RESET,
				pre_cnt: '0, rx_state: rx_idle, rx_cnt: 4'h0, rx_flag: 1'b0, tx_active: 1'b0,
				tx_cnt: 4'h0, txd: 1'b1, irq_status: '0, irq_enable: '0};
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// outputs

	assign hreadyout = !state_reg.dp_read || state_reg.rd_wait;
	assign hresp = 1'b0;
	assign hrdata = state_reg.rdata;
	assign txd = state_reg.txd;
	assign irq = |(state_reg.irq_status & state_reg.irq_enable);

endmodule

/* shared/brg_pkg.sv */
// Purpose: constants and types shared by the baud and break control block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: offsets are byte addresses
package brg_pkg;

	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_BAUD = 8'h04;
	localparam logic [7:0] ADDR_CLKSEL = 8'h08;
	localparam logic [7:0] ADDR_BREAK = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h18;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1C;

	// serial_mode_reg fields
	localparam int POWER_BIT = 7;
	localparam int TXE_BIT = 6;
	localparam int RXE_BIT = 5;
	// break_control_reg fields
	localparam int BRK_TX_START_BIT = 7;
	localparam int BRK_RX_START_BIT = 6;
	// status register fields
	localparam int ST_RX_FLAG_BIT = 0;
	localparam int ST_RX_ACTIVE_BIT = 1;
	localparam int ST_TX_ACTIVE_BIT = 2;
	// interrupt status / clear / enable layout
	localparam int IRQ_RX_DONE = 0;
	localparam int IRQ_RX_ERR = 1;
	localparam int IRQ_TX_DONE = 2;
	localparam int IRQ_W = 3;

	localparam logic [7:0] DIVISOR_RESET = 8'hFF;
	localparam logic [3:0] CLKSEL_RESET = 4'h0;
	localparam logic [3:0] CLKSEL_MAX = 4'hA;
	localparam int PRE_W = 10;
	localparam logic [3:0] BREAK_TX_BITS = 4'hD;
	localparam logic [3:0] BREAK_RX_MIN_BITS = 4'hB;

	typedef enum logic [1:0] {rx_idle, rx_wait_low, rx_count} rx_state_e;

endpackage

/* testbench/remote_node.sv */
// Purpose: remote serial node that sends a break on the line
// Assumes: go is a one-cycle pulse
// Notes: line rests at its idle high level between breaks
module remote_node
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic go,
	input wire logic [15:0] low_cyc,
	output logic rxd
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] cnt;
	assign rxd = (cnt == 16'h0000);
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cnt <= 16'h0000;
		else if (go)
			cnt <= low_cyc;
		else if (cnt != 16'h0000)
			cnt <= cnt - 16'h0001;
	end
endmodule

/* testbench/tb_top.sv */
// Purpose: self-checking bench for the baud and break block
// Assumes: divisor 1 and clock select 0, four hclk per bit, except in the rate scenario
// Notes: bus tasks keep both AHB-Lite phases whole
module tb_top
	import brg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BIT = 4;
	// divisor 2, select 1: two counter periods of three base ticks, base tick every 2 hclk
	localparam int BIT_SLOW = 12;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b1;
	logic hwrite = 1'b0;
	logic go = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [15:0] low_cyc = 16'h0;
	logic [31:0] hrdata;
	logic [31:0] d;
	logic hreadyout;
	logic hresp;
	logic rxd;
	logic txd;
	logic irq;
	int n_fail = 0;
	int compares = 0;
	int lo;
	uart_baud_and_break_control dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .rxd, .txd, .irq);
	remote_node rn (.hclk, .hresetn, .go, .low_cyc, .rxd);
	initial
	begin
		forever #5 hclk = ~hclk;
	end
	////////////////////////////////////////
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task conclude;
		if (n_fail == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] v);
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= v;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		d = hrdata;
	endtask
	task rbk(input logic [7:0] a, input logic [31:0] e, input string nm);
		xfer(1'b0, a, 32'h0);
		chk(nm, d, e);
	endtask
	// counts low line cycles; bounded so a lost interrupt cannot hang
	task wirq;
		lo = 0;
		for (int i = 0; i < 400 && irq !== 1'b1; i++)
		begin
			@(posedge hclk);
			lo += int'(txd === 1'b0);
		end
		chk("irq_up", irq, 32'h1);
	endtask
	////////////////////////////////////////
	task t_reset;
		rbk(ADDR_MODE, 32'h0, "mode");
		rbk(ADDR_BAUD, 32'hFF, "baud");
		rbk(ADDR_CLKSEL, 32'h0, "clksel");
		xfer(1'b1, ADDR_BREAK, 32'hC0);
		xfer(1'b1, ADDR_STATUS, 32'h7);
		xfer(1'b1, 8'h40, 32'h5);
		rbk(ADDR_STATUS, 32'h0, "status_ro");
		rbk(8'h40, 32'h0, "unmapped");
		chk("txd_idle", txd, 32'h1);
	endtask
	task t_tx;
		xfer(1'b1, ADDR_CLKSEL, 32'h0);
		xfer(1'b1, ADDR_BAUD, 32'h1);
		xfer(1'b1, ADDR_MODE, 32'h80);
		xfer(1'b1, ADDR_MODE, 32'hE0);
		xfer(1'b1, ADDR_IRQ_ENABLE, 32'h7);
		xfer(1'b1, ADDR_BREAK, 32'h80);
		wirq();
		chk("tx_low_min", lo > 12 * BIT, 32'h1);
		chk("tx_low_max", lo <= 13 * BIT + 1, 32'h1);
		rbk(ADDR_IRQ_STATUS, 32'h4, "tx_done");
		xfer(1'b1, ADDR_IRQ_ENABLE, 32'h0);
		@(posedge hclk);
		chk("irq_masked", irq, 32'h0);
		xfer(1'b1, ADDR_IRQ_ENABLE, 32'h7);
		@(posedge hclk);
		chk("irq_unmasked", irq, 32'h1);
		xfer(1'b1, ADDR_IRQ_CLEAR, 32'h7);
		@(posedge hclk);
		chk("irq_cleared", irq, 32'h0);
	endtask
	task t_refresh;
		xfer(1'b1, ADDR_BREAK, 32'h80);
		repeat (20) @(posedge hclk);
		xfer(1'b1, ADDR_BREAK, 32'h80);
		wirq();
		chk("refresh_restart", lo > 12 * BIT, 32'h1);
	endtask
	task rx(input logic [15:0] n);
		xfer(1'b1, ADDR_IRQ_CLEAR, 32'h7);
		xfer(1'b1, ADDR_BREAK, 32'h40);
		rbk(ADDR_BREAK, 32'h0, "rx_start_read");
		xfer(1'b0, ADDR_STATUS, 32'h0);
		chk("rx_flag_armed", d[ST_RX_FLAG_BIT], 32'h1);
		low_cyc <= n;
		go <= 1'b1;
		@(posedge hclk);
		go <= 1'b0;
		wirq();
	endtask
	task t_rx_err;
		rx(16'(6 * BIT));
		rbk(ADDR_IRQ_STATUS, 32'h2, "rx_err");
		xfer(1'b0, ADDR_STATUS, 32'h0);
		chk("rx_flag_held", d[ST_RX_FLAG_BIT], 32'h1);
	endtask
	task t_rx_ok;
		rx(16'(14 * BIT));
		rbk(ADDR_IRQ_STATUS, 32'h1, "rx_done");
		xfer(1'b0, ADDR_STATUS, 32'h0);
		chk("rx_flag_done", d[ST_RX_FLAG_BIT], 32'h0);
	endtask
	// other divisor and base clock; an unselected write must not land
	task t_rate;
		xfer(1'b1, ADDR_IRQ_CLEAR, 32'h7);
		xfer(1'b1, ADDR_MODE, 32'h80);
		xfer(1'b1, ADDR_MODE, 32'h0);
		xfer(1'b1, ADDR_CLKSEL, 32'h1);
		xfer(1'b1, ADDR_BAUD, 32'h2);
		hsel <= 1'b0;
		xfer(1'b1, ADDR_BAUD, 32'h55);
		hsel <= 1'b1;
		rbk(ADDR_BAUD, 32'h2, "baud_unselected");
		rbk(ADDR_CLKSEL, 32'h1, "clksel_set");
		xfer(1'b1, ADDR_MODE, 32'h80);
		xfer(1'b1, ADDR_MODE, 32'hE0);
		rbk(ADDR_MODE, 32'hE0, "mode_on");
		xfer(1'b1, ADDR_BREAK, 32'h80);
		wirq();
		chk("rate_low_min", lo > 12 * BIT_SLOW, 32'h1);
		chk("rate_low_max", lo <= 13 * BIT_SLOW, 32'h1);
		rbk(ADDR_IRQ_STATUS, 32'h4, "rate_tx_done");
	endtask
	initial
	begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_tx();
		t_refresh();
		t_rx_err();
		t_rx_ok();
		t_rate();
		conclude();
	end
	initial
	begin
		#100000;
		n_fail++;
		conclude();
	end
endmodule

/* testbench/uart_monitor.sv */
// Purpose: port checker for the baud and break block
// Assumes: a bit period of at least BIT_CYC hclk while a break is sent
// Notes: bound into every instance of the top module
module uart_monitor
	import brg_pkg::*;
#(
	parameter int BIT_CYC = 4
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic txd,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LOW_MIN = 12 * BIT_CYC + 1;
	logic tk;
	logic w_q;
	logic r_q;
	logic [7:0] a_q;
	logic [15:0] lo;
	assign tk = hsel && htrans[1] && hready;
	// phase tracking follows hready so a stalled read stays open
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			a_q <= 8'h00;
			w_q <= 1'b0;
			r_q <= 1'b0;
			lo <= 16'h0000;
		end
		else
		begin
			if (hready)
			begin
				a_q <= haddr[7:0];
				w_q <= tk && hwrite;
				r_q <= tk && !hwrite;
			end
			lo <= txd ? 16'h0000 : lo + 16'h0001;
		end
	end
	default clocking dc @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	AST_OKAY: assert property (hresp == 1'b0) else $error("hresp not okay");
	AST_RD_WAIT: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
	AST_WR_NOWAIT: assert property (tk && hwrite |=> hreadyout) else $error("write stalled");
	AST_RX_START_ZERO: assert property (r_q && hreadyout && a_q == ADDR_BREAK |-> !hrdata[BRK_RX_START_BIT])
		else $error("break receive start read back set");
	AST_UPPER_ZERO: assert property (r_q && hreadyout |-> hrdata[31:8] == 24'h000000) else $error("upper bits set");
	AST_UNMAPPED: assert property (r_q && hreadyout && a_q > ADDR_IRQ_ENABLE |-> hrdata == 32'h00000000)
		else $error("unmapped read not zero");
	AST_IRQ_MASK: assert property (w_q && hreadyout && a_q == ADDR_IRQ_ENABLE && hwdata[2:0] == 3'h0 |=> !irq)
		else $error("irq not masked");
	AST_TX_LEN: assert property ($rose(txd) |-> lo >= LOW_MIN) else $error("break sent too short");
	AST_RST: assert property ($rose(hresetn) |-> hreadyout && txd && !irq) else $error("bad state after reset");
	cover property ($rose(txd));
	cover property ($rose(irq));
	cover property (r_q && hreadyout && a_q == ADDR_BREAK);
endmodule
////////////////////////////////////////
bind uart_baud_and_break_control uart_monitor mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .hreadyout, .hresp, .hrdata, .txd, .irq);
